// ===== rtl/adc_seq_pkg.sv
// Purpose: Constants for the multichannel ADC sampling sequencer
// Assumes: 125 MHz clock, 12-bit converter
// Notes: Register offsets are word addresses on the plain register port
package adc_seq_pkg;
   localparam int CLK_MHZ = 125;
   localparam int CODE_W = 12;
   localparam logic [11:0] CODE_MAX = 12'hFFF;
   localparam logic [11:0] CODE_MID = 12'h800;
   localparam logic [12:0] SPAN_STEPS = 13'h1000;
   // Conversion slot and scan overhead, in microseconds
   localparam int CONV_US = 10;
   localparam int OVERHEAD_US = 20;
   localparam int CONV_CYC = CONV_US * CLK_MHZ;
   localparam int OVERHEAD_CYC = OVERHEAD_US * CLK_MHZ;
   localparam int MEM_WORDS = 262144;
   localparam int ADDR_W = 18;
   localparam int MAX_CH = 32;
   localparam int CH_W = 5;
   // Range encodings
   localparam logic [1:0] RNG_U5 = 2'h0;
   localparam logic [1:0] RNG_U10 = 2'h1;
   localparam logic [1:0] RNG_B5 = 2'h2;
   localparam logic [1:0] RNG_B10 = 2'h3;
   // Register word addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CHCNT = 4'h1;
   localparam logic [3:0] REG_PERIOD = 4'h2;
   localparam logic [3:0] REG_TRIG = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_FILL = 4'h5;
   localparam logic [3:0] REG_DATA = 4'h6;
   localparam logic [3:0] REG_CMD = 4'h7;
   // CTRL fields
   localparam int CTRL_RANGE_LSB = 0;
   localparam int CTRL_TRIGMODE = 2;
   // CMD bits
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_CLR = 2;
   // TRIG fields: threshold 11:0, channel 20:16, rising 24, level stop 25
   localparam int TRIG_CH_LSB = 16;
   localparam int TRIG_RISE = 24;
   localparam int TRIG_STOPEN = 25;
   // STATUS bits
   localparam int ST_RUN = 0;
   localparam int ST_SAMPERR = 1;
   localparam int ST_OVF = 2;
   localparam int ST_EMPTY = 3;
   localparam int ST_FULL = 4;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_CONV, SEQ_WAIT} seq_state_t;
endpackage

// ===== rtl/adc_sampling_sequencer.sv
// Purpose: Scan, code, pace, trigger and buffer analog samples for the host
// Assumes: Converter model returns signed millivolts per channel on request
// Notes: Block drain is a burst of data-register reads from the host side
`timescale 1ns/1ns
// Function
// - deliver 12-bit code over selected range
// - four ranges selectable by host
// - unipolar straight binary, span over 4096
// - 0-5 V step is 1.22 mV
// - over-range saturates at all ones
// - bipolar offset binary, zero at midscale
// - plus/minus 5 V step 2.44 mV
// - scan time channels times slot plus 20us
// - channels in order, 10us apart
// - period shorter than scan raises error
// - each scan result stored in buffer
// - results drained in blocks by host
// - buffer shared among active channels
// - buffer runs as circular FIFO
// - software command starts and stops
// - level trigger on chosen channel
// - no cross-module sync of conversions
module adc_sampling_sequencer
   import adc_seq_pkg::*;
#(
   parameter int ADDR_BITS = adc_seq_pkg::ADDR_W,
   parameter int SLOT_CYC = adc_seq_pkg::CONV_CYC,
   parameter int OVH_CYC = adc_seq_pkg::OVERHEAD_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   output logic convStart,
   output logic [adc_seq_pkg::CH_W-1:0] convChannel,
   input wire logic signed [15:0] convMilliVolt,
   output logic scanDone
);
   import adc_seq_pkg::*;

   localparam int DEPTH = 1 << ADDR_BITS;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      seq_state_t st;
      logic [1:0] range;
      logic trigLevel;
      logic [CH_W:0] chCount;
      logic [31:0] period;
      logic [31:0] trig;
      logic [31:0] timer;
      logic [31:0] periodCnt;
      logic [CH_W-1:0] ch;
      logic sampErr;
      logic ovf;
      logic [ADDR_BITS-1:0] wrPtr;
      logic [ADDR_BITS-1:0] rdPtr;
      logic [ADDR_BITS:0] fill;
      logic [CODE_W-1:0] lastTrig;
      logic haveLast;
      logic armed;
      logic [31:0] rdData;
      logic convStart;
      logic scanDone;
   } state_t;

   state_t s_q, s_d;
   logic [CODE_W-1:0] mem [DEPTH];
   logic [CODE_W-1:0] memOut;
   logic [CODE_W-1:0] code;
   logic memWr;
   logic memRdEn;
   logic crossed;

   // ************************************************************
   // Voltage to code
   // ************************************************************
   // Millivolts scaled by 4096/span; signed math keeps the negative
   // side of bipolar ranges from wrapping before the clamp
   function automatic logic [CODE_W-1:0] toCode(input logic signed [15:0] mv,
                                               input logic [1:0] rng);
      logic signed [31:0] spanMv;
      logic signed [31:0] offMv;
      logic signed [31:0] raw;
      spanMv = 32'sd5000;
      offMv = 32'sd0;
      case (rng)
         RNG_U5: spanMv = 32'sd5000;
         RNG_U10: spanMv = 32'sd10000;
         RNG_B5:
         begin
            spanMv = 32'sd10000;
            offMv = 32'sd5000;
         end
         default:
         begin
            spanMv = 32'sd20000;
            offMv = 32'sd10000;
         end
      endcase
      // Signed step count, so below-range inputs clamp to zero instead of wrapping
      raw = ((32'(mv) + offMv) * $signed(32'(SPAN_STEPS))) / spanMv;
      if (raw < 0)
         toCode = '0;
      else if (raw > 32'(CODE_MAX))
         toCode = CODE_MAX;
      else
         toCode = raw[CODE_W-1:0];
   endfunction

   assign code = toCode(convMilliVolt, s_q.range);

   // Level-trigger crossing of the chosen channel
   always_comb
   begin
      crossed = 1'b0;
      if (s_q.haveLast && convChannel == s_q.trig[TRIG_CH_LSB +: CH_W])
      begin
         if (s_q.trig[TRIG_RISE])
            crossed = s_q.lastTrig < s_q.trig[CODE_W-1:0] &&
               code >= s_q.trig[CODE_W-1:0];
         else
            crossed = s_q.lastTrig > s_q.trig[CODE_W-1:0] &&
               code <= s_q.trig[CODE_W-1:0];
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      logic pop;
      s_d = s_q;
      pop = 1'b0;
      memWr = 1'b0;
      s_d.convStart = 1'b0;
      s_d.scanDone = 1'b0;
      // Register writes
      if (regWr)
      begin
         case (regAddr)
            REG_CTRL:
            begin
               s_d.range = regWrData[CTRL_RANGE_LSB +: 2];
               s_d.trigLevel = regWrData[CTRL_TRIGMODE];
            end
            REG_CHCNT: s_d.chCount = regWrData[CH_W:0];
            REG_PERIOD: s_d.period = regWrData;
            REG_TRIG: s_d.trig = regWrData;
            REG_CMD:
            begin
               if (regWrData[CMD_CLR])
               begin
                  s_d.sampErr = 1'b0;
                  s_d.ovf = 1'b0;
               end
               if (regWrData[CMD_START] && s_q.st == SEQ_IDLE)
               begin
                  s_d.st = s_q.trigLevel ? SEQ_ARMED : SEQ_CONV;
                  s_d.ch = '0;
                  s_d.timer = '0;
                  s_d.periodCnt = '0;
                  s_d.haveLast = 1'b0;
                  s_d.armed = s_q.trigLevel;
                  s_d.convStart = 1'b1;
               end
               if (regWrData[CMD_STOP])
                  s_d.st = SEQ_IDLE;
            end
            default: ;
         endcase
      end
      // Host drain of the data register, one word per read
      if (regRd && regAddr == REG_DATA && s_q.fill != '0)
         pop = 1'b1;
      // Sequencer; runs only on this module's own clock
      if (s_q.st != SEQ_IDLE && !(regWr && regAddr == REG_CMD && regWrData[CMD_STOP]))
      begin
         s_d.periodCnt = s_q.periodCnt + 32'h1;
         case (s_q.st)
            SEQ_ARMED, SEQ_CONV:
            begin
               if (s_q.timer == 32'(SLOT_CYC - 1))
               begin
                  s_d.timer = '0;
                  s_d.lastTrig = (convChannel == s_q.trig[TRIG_CH_LSB +: CH_W]) ?
                     code : s_q.lastTrig;
                  s_d.haveLast = s_q.haveLast ||
                     (convChannel == s_q.trig[TRIG_CH_LSB +: CH_W]);
                  if (s_q.st == SEQ_ARMED && crossed)
                  begin
                     s_d.st = SEQ_CONV;
                     s_d.armed = 1'b0;
                  end
                  if (s_q.st == SEQ_CONV && s_q.trigLevel &&
                      s_q.trig[TRIG_STOPEN] && crossed)
                     s_d.st = SEQ_IDLE;
                  if (s_q.st == SEQ_CONV && !s_d.ovf)
                  begin
                     if (32'(s_q.fill) >= 32'(DEPTH))
                        s_d.ovf = 1'b1;
                     else
                        memWr = 1'b1;
                  end
                  if (32'(s_q.ch) + 32'h1 >= 32'(s_q.chCount))
                  begin
                     s_d.ch = '0;
                     if (s_d.st != SEQ_IDLE)
                        s_d.st = SEQ_WAIT;
                     if (s_q.st == SEQ_ARMED && !crossed)
                        s_d.st = SEQ_WAIT;
                  end
                  else
                  begin
                     s_d.ch = s_q.ch + 1'b1;
                     s_d.convStart = 1'b1;
                  end
               end
               else
                  s_d.timer = s_q.timer + 32'h1;
            end
            SEQ_WAIT:
            begin
               // Fixed overhead after the last slot of a scan
               if (s_q.timer == 32'(OVH_CYC - 1))
                  s_d.scanDone = 1'b1;
               if (s_q.timer < 32'(OVH_CYC))
                  s_d.timer = s_q.timer + 32'h1;
               if (s_q.periodCnt + 32'h1 >= s_q.period)
               begin
                  if (s_q.timer < 32'(OVH_CYC))
                     s_d.sampErr = 1'b1;
                  s_d.periodCnt = '0;
                  s_d.timer = '0;
                  // Stay armed across scans until the crossing is seen
                  s_d.st = s_q.armed ? SEQ_ARMED : SEQ_CONV;
                  s_d.convStart = 1'b1;
               end
            end
            default: s_d.st = SEQ_IDLE;
         endcase
         // A period that ends before the scan finishes is also an error
         if (s_q.st != SEQ_WAIT && s_q.periodCnt + 32'h1 >= s_q.period &&
             s_q.period != '0)
            s_d.sampErr = 1'b1;
      end
      // Circular pointers, wrap by natural overflow
      if (memWr)
         s_d.wrPtr = s_q.wrPtr + 1'b1;
      if (pop)
         s_d.rdPtr = s_q.rdPtr + 1'b1;
      s_d.fill = s_q.fill + (memWr ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      // Read data, one cycle after the strobe
      s_d.rdData = '0;
      if (regRd)
      begin
         case (regAddr)
            REG_CTRL: s_d.rdData = {29'h0, s_q.trigLevel, s_q.range};
            REG_CHCNT: s_d.rdData = 32'(s_q.chCount);
            REG_PERIOD: s_d.rdData = s_q.period;
            REG_TRIG: s_d.rdData = s_q.trig;
            REG_STATUS:
            begin
               s_d.rdData[ST_RUN] = s_q.st != SEQ_IDLE;
               s_d.rdData[ST_SAMPERR] = s_q.sampErr;
               s_d.rdData[ST_OVF] = s_q.ovf;
               s_d.rdData[ST_EMPTY] = s_q.fill == '0;
               s_d.rdData[ST_FULL] = 32'(s_q.fill) >= 32'(DEPTH);
            end
            REG_FILL: s_d.rdData = 32'(s_q.fill);
            default: s_d.rdData = '0;
         endcase
      end
      if (reset)
      begin
         s_d = '0;
         memWr = 1'b0;
         s_d.st = SEQ_IDLE;
         s_d.chCount = (CH_W+1)'(1);
         s_d.range = RNG_B10;
      end
   end

   always_ff @(posedge clk)
      s_q <= s_d;

   // ************************************************************
   // Sample memory, registered read port
   // ************************************************************
   assign memRdEn = regRd && regAddr == REG_DATA;
   always_ff @(posedge clk)
   begin
      if (memWr)
         mem[s_q.wrPtr] <= code;
      memOut <= mem[s_q.rdPtr];
   end

   logic dataSel_q;
   always_ff @(posedge clk)
      dataSel_q <= memRdEn && !reset;

   // no external sync input exists; each instance paces itself
   assign regRdData = dataSel_q ? {20'h0, memOut} : s_q.rdData;
   assign convStart = s_q.convStart;
   assign convChannel = s_q.ch;
   assign scanDone = s_q.scanDone;

   // ************************************************************
   // Checks
   // ************************************************************
   property p_sat;
      @(posedge clk) disable iff (reset)
      (convMilliVolt > 16'sd10000) |-> code == CODE_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("over-range code not saturated");

   property p_mid;
      @(posedge clk) disable iff (reset)
      (s_q.range == RNG_B10 && convMilliVolt == 16'sd0) |-> code == CODE_MID;
   endproperty
   a_mid: assert property (p_mid) else $error("zero volts not midscale");

   property p_order;
      @(posedge clk) disable iff (reset)
      (s_q.convStart && s_q.st == SEQ_CONV && s_q.ch != '0) |->
         $past(s_q.ch) == s_q.ch - 1'b1;
   endproperty
   a_order: assert property (p_order) else $error("channel order broken");

   property p_ovf;
      @(posedge clk) disable iff (reset)
      (memWr) |-> 32'(s_q.fill) < 32'(DEPTH);
   endproperty
   a_ovf: assert property (p_ovf) else $error("write into full buffer");

   property p_fill;
      @(posedge clk) disable iff (reset)
      1'b1 |=> s_q.fill == $past(s_q.fill) + $past(memWr) -
         ($past(regRd && regAddr == REG_DATA && s_q.fill != '0) ? 1'b1 : 1'b0);
   endproperty
   a_fill: assert property (p_fill) else $error("fill count wrong");

   property p_stop;
      @(posedge clk) disable iff (reset)
      (regWr && regAddr == REG_CMD && regWrData[CMD_STOP]) |=> s_q.st == SEQ_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop command ignored");

   property p_err;
      @(posedge clk) disable iff (reset)
      (s_q.st == SEQ_WAIT && s_q.timer < 32'(OVH_CYC) &&
       s_q.periodCnt + 32'h1 >= s_q.period && !(regWr && regAddr == REG_CMD))
         |=> s_q.sampErr;
   endproperty
   a_err: assert property (p_err) else $error("sampling error not raised");

   property p_u10;
      @(posedge clk) disable iff (reset)
      (s_q.range == RNG_U10 && convMilliVolt == 16'sd5000) |-> code == CODE_MID;
   endproperty
   a_u10: assert property (p_u10) else $error("unipolar midscale wrong");

endmodule

// ===== verif/conv_model.sv
// Purpose: Converter stand-in facing the sampling sequencer
// Assumes: One result per convStart, looked up from a per-channel table
// Notes: Result holds until the next conversion, like a converter output latch
`timescale 1ns/1ns
module conv_model
(
   input wire logic clk,
   input wire logic convStart,
   input wire logic [4:0] convChannel,
   input wire logic signed [15:0] mvTable [0:3],
   output logic signed [15:0] convMilliVolt
);
   // Latch the chosen channel as a slot opens; only four channels are modelled
   initial convMilliVolt = 16'sh0000;
   always @(posedge clk)
   begin
      if (convStart === 1'b1)
      begin
         convMilliVolt <= mvTable[convChannel[1:0]];
      end
   end
endmodule

// ===== verif/multichannel_adc_sampling_sequencer_bench.sv
// Purpose: Self-checking bench for the sampling sequencer
// Assumes: Short slot and overhead counts, 16-word buffer
// Notes: Expected codes worked by hand from range span and offset
`timescale 1ns/1ns
module multichannel_adc_sampling_sequencer_bench;
   import adc_seq_pkg::*;
   localparam int SLOT = 4;
   localparam int OVH = 8;
   localparam int DEPTH = 16;
   typedef struct {logic [1:0] rng; logic signed [15:0] mv; logic [11:0] code;} row_t;
   logic clk, reset, regWr, regRd, convStart, scanDone;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData, rdVal;
   logic [4:0] convChannel;
   logic signed [15:0] convMilliVolt;
   logic signed [15:0] mvTable [0:3];
   int err_count, check_count, cyc, doneCyc;
   int startCyc[$];
   logic [4:0] startCh[$];
   row_t rows [0:13];
   logic [31:0] scanExp [0:2] = '{32'h800, 32'hC00, 32'h400};
   logic [31:0] rstExp [0:5] = '{32'h3, 32'h1, 32'h0, 32'h0, 32'h8, 32'h0};

   adc_sampling_sequencer #(.ADDR_BITS(4), .SLOT_CYC(SLOT), .OVH_CYC(OVH)) uut
   (
      .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .convStart(convStart),
      .convChannel(convChannel), .convMilliVolt(convMilliVolt), .scanDone(scanDone)
   );
   conv_model conv
   (
      .clk(clk), .convStart(convStart), .convChannel(convChannel),
      .mvTable(mvTable), .convMilliVolt(convMilliVolt)
   );

   // Free-running 8 ns clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Log slot starts and scan ends by cycle number
   always @(posedge clk)
   begin
      cyc++;
      if (convStart === 1'b1)
      begin
         startCyc.push_back(cyc);
         startCh.push_back(convChannel);
      end
      if (scanDone === 1'b1)
         doneCyc = cyc;
   end

   // Watchdog: whole run needs about 1500 cycles
   initial
   begin
      repeat (12000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe, so grab it there
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdVal = regRdData;
   endtask

   // Always steps one edge first, so a pulse is never counted twice
   task automatic waitDone;
      int i;
      i = 0;
      do
      begin
         @(posedge clk);
         #1;
         i++;
      end while (scanDone !== 1'b1 && i < 400);
      chk("scanDone", {31'h0, scanDone}, 32'h1);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      reset = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 32'h0;
      mvTable = '{default: 16'sh0000};
      // Voltages in mV: 0, 2500, 5000, 12000, -2500, -10000
      rows[0:3] = '{'{RNG_U5, 16'sh0000, 12'h000}, '{RNG_U5, 16'sh09C4, 12'h800},
         '{RNG_U5, 16'sh1388, 12'hFFF}, '{RNG_U10, 16'sh09C4, 12'h400}};
      rows[4:7] = '{'{RNG_U10, 16'sh1388, 12'h800}, '{RNG_U10, 16'sh2EE0, 12'hFFF},
         '{RNG_B5, 16'sh0000, 12'h800}, '{RNG_B5, 16'shF63C, 12'h400}};
      rows[8:11] = '{'{RNG_B5, 16'sh09C4, 12'hC00}, '{RNG_B5, 16'sh1388, 12'hFFF},
         '{RNG_B10, 16'sh0000, 12'h800}, '{RNG_B10, 16'sh1388, 12'hC00}};
      rows[12:13] = '{'{RNG_B10, 16'shD8F0, 12'h000}, '{RNG_B10, 16'sh2EE0, 12'hFFF}};
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      wr(REG_PERIOD, 32'h28);
      for (int r = 0; r < 14; r++)
      begin
         mvTable[0] <= rows[r].mv;
         wr(REG_CTRL, {30'h0, rows[r].rng});
         wr(REG_CMD, 32'h1);
         waitDone();
         wr(REG_CMD, 32'h2);
         rd(REG_FILL);
         chk("fill", rdVal, 32'h1);
         rd(REG_DATA);
         chk("code", rdVal, {20'h0, rows[r].code});
      end
      $display("test done: range codes");
      // Three channels, order and spacing of slots
      mvTable <= '{16'sh0000, 16'sh1388, 16'shEC78, 16'sh0000};
      wr(REG_CTRL, 32'h3);
      wr(REG_CHCNT, 32'h3);
      startCyc.delete();
      startCh.delete();
      wr(REG_CMD, 32'h1);
      waitDone();
      wr(REG_CMD, 32'h2);
      for (int c = 0; c < 3; c++)
      begin
         chk("channel", {27'h0, startCh[c]}, c);
         chk("slot gap", startCyc[c] - startCyc[0], c * SLOT);
      end
      chk("scan time", doneCyc - startCyc[0], 3 * SLOT + OVH);
      rd(REG_STATUS);
      chk("no sampling error", {31'h0, rdVal[ST_SAMPERR]}, 32'h0);
      rd(REG_FILL);
      chk("fill", rdVal, 32'h3);
      for (int c = 0; c < 3; c++)
      begin
         rd(REG_DATA);
         chk("scan code", rdVal, scanExp[c]);
      end
      $display("test done: scan order");
      // Period shorter than the scan
      wr(REG_PERIOD, 32'hA);
      wr(REG_CMD, 32'h1);
      repeat (40) @(posedge clk);
      wr(REG_CMD, 32'h2);
      rd(REG_STATUS);
      chk("sampling error", {31'h0, rdVal[ST_SAMPERR]}, 32'h1);
      wr(REG_CMD, 32'h4);
      rd(REG_STATUS);
      chk("error cleared", {31'h0, rdVal[ST_SAMPERR]}, 32'h0);
      // Drain what the short-period scans stored before the overflow case
      rd(REG_FILL);
      repeat (rdVal[4:0]) rd(REG_DATA);
      rd(REG_STATUS);
      chk("drained empty", {31'h0, rdVal[ST_EMPTY]}, 32'h1);
      $display("test done: sampling error");
      // Fill past capacity, then drain
      wr(REG_PERIOD, 32'h28);
      wr(REG_CHCNT, 32'h1);
      wr(REG_CMD, 32'h1);
      repeat (DEPTH + 2) waitDone();
      wr(REG_CMD, 32'h2);
      rd(REG_STATUS);
      chk("full flags", {29'h0, rdVal[ST_FULL:ST_OVF]}, 32'h5);
      rd(REG_FILL);
      chk("fill", rdVal, DEPTH);
      for (int k = 0; k < DEPTH; k++)
      begin
         rd(REG_DATA);
         chk("drained", rdVal, 32'h800);
      end
      rd(REG_STATUS);
      chk("empty", {31'h0, rdVal[ST_EMPTY]}, 32'h1);
      wr(REG_CMD, 32'h4);
      $display("test done: overflow");
      // Rising crossing of 800h on channel 0
      mvTable[0] <= 16'shEC78;
      wr(REG_TRIG, 32'h01000800);
      wr(REG_CTRL, 32'h7);
      wr(REG_CMD, 32'h1);
      repeat (3) waitDone();
      rd(REG_FILL);
      chk("armed fill", rdVal, 32'h0);
      mvTable[0] <= 16'sh1388;
      repeat (3) waitDone();
      wr(REG_CMD, 32'h2);
      rd(REG_FILL);
      chk("triggered", {31'h0, rdVal != 32'h0}, 32'h1);
      $display("test done: level trigger");
      // Unmapped place, then reset with the sequencer stopped
      wr(4'h9, 32'hFFFFFFFF);
      rd(4'h9);
      chk("unmapped", rdVal, 32'h0);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 6; a++)
      begin
         rd(a[3:0]);
         chk("reset value", rdVal, rstExp[a]);
      end
      $display("test done: reset");
      close_out();
   end
endmodule
